// ==== pkg/gpib_interrupt_status_two_pkg.sv ====
package gpib_interrupt_status_two_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0]  ADDR_STATUS_TWO = 8'h00;
	localparam logic [7:0]  ADDR_MASK_TWO   = 8'h04;
	localparam logic [7:0]  ADDR_RL_STATE   = 8'h08;
	localparam logic [7:0]  ADDR_CMD_OUT    = 8'h0C;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int POS_SRQ_IN   = 6;
	localparam int POS_LOCKOUT  = 5;
	localparam int POS_DMA_OUT  = 5;
	localparam int POS_REMOTE   = 4;
	localparam int POS_DMA_IN   = 4;
	localparam int POS_CMD_OUT  = 3;
	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0]  MASK_RESET = 8'h00;
	localparam logic [31:0] READ_ZERO  = 32'h0000_0000;
	// remote/local function states, gray along local->remote->rwls
	typedef enum logic [2:0] {
		RL_LOCS = 3'b000,
		RL_REMS = 3'b001,
		RL_RWLS = 3'b011,
		RL_LWLS = 3'b010
	} rl_state_t;
endpackage

// ==== src/gpib_interrupt_status_two_mid.sv ====
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - set service request flag when in charge, bus request seen, not own request byte
// - clear service request flag at reset and right after a status read
// - lockout bit reads one in local-with-lockout or remote-with-lockout
// - lockout bit never feeds the interrupt and has no enable
// - remote bit reads one in remote or remote-with-lockout state
// - remote entered only with remote enable asserted and addressed as listener
// - set command output flag when controller active and source generate
// - clear command output flag on status read or leaving either state
// - command output flag means command output register empty
// - interrupt on event with enable set; status changes regardless of enable
// - changes arriving during a status read wait until the read ends
// - interrupt is the or of the service request and command output flags, each anded with its enable
module gpib_interrupt_status_two_mid
	import gpib_interrupt_status_two_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        controller_in_charge,
	input  wire logic        bus_srq,
	input  wire logic        rqs_dav,
	input  wire logic        cacs,
	input  wire logic        sgns,
	input  wire logic        bus_ren,
	input  wire logic        listen_addressed,
	input  wire logic        go_local,
	input  wire logic        lockout_cmd,
	output logic             irq,
	output logic             dma_out_enable,
	output logic             dma_in_enable
);
	import gpib_interrupt_status_two_pkg::*;
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	// every bus-side level crosses in through two flops; nothing reads the first
	localparam int NUM_PINS = 9;
	logic [NUM_PINS-1:0] pin_raw;
	logic [NUM_PINS-1:0] sync1;
	logic [NUM_PINS-1:0] sync2;
	assign pin_raw = {controller_in_charge,
		bus_srq,
		rqs_dav,
		cacs,
		sgns,
		bus_ren,
		listen_addressed,
		go_local,
		lockout_cmd};
	generate
		for (genvar i = 0; i < NUM_PINS; i++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync1[i] <= 1'b0;
					sync2[i] <= 1'b0;
				end else begin
					sync1[i] <= pin_raw[i];
					sync2[i] <= sync1[i];
				end
			end
		end
	endgenerate
	logic in_charge_s;
	logic srq_s;
	logic rqsdav_s;
	logic cacs_s;
	logic sgns_s;
	logic ren_s;
	logic ladr_s;
	logic gtl_s;
	logic lockout_s;
	assign {in_charge_s, srq_s, rqsdav_s, cacs_s, sgns_s, ren_s, ladr_s, gtl_s,
		lockout_s} = sync2;
	// ************************************************************
	// apb decode
	// ************************************************************
	logic access;
	logic rd_status;
	logic wr_mask;
	logic read_busy;
	assign access    = psel && penable;
	assign rd_status = access && !pwrite && (paddr == ADDR_STATUS_TWO);
	assign wr_mask   = access && pwrite && (paddr == ADDR_MASK_TWO);
	// setup cycle of a status read: the word is being captured, so flags stay put
	assign read_busy = psel && !pwrite && (paddr == ADDR_STATUS_TWO) && !penable;
	// ************************************************************
	// remote/local function
	// ************************************************************
	rl_state_t rl_state;
	rl_state_t next_rl_state;
	always_comb begin
		next_rl_state = rl_state;
		if (!ren_s) begin
			next_rl_state = RL_LOCS;
		end else begin
			case (rl_state)
				RL_LOCS: begin
					if (ladr_s) begin
						next_rl_state = lockout_s ? RL_RWLS : RL_REMS;
					end
				end
				RL_REMS: begin
					if (lockout_s) begin
						next_rl_state = RL_RWLS;
					end else if (gtl_s) begin
						next_rl_state = RL_LOCS;
					end
				end
				RL_RWLS: begin
					if (gtl_s) begin
						next_rl_state = RL_LWLS;
					end
				end
				RL_LWLS: begin
					if (ladr_s) begin
						next_rl_state = RL_RWLS;
					end
				end
				default: begin
					next_rl_state = RL_LOCS;
				end
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rl_state <= RL_LOCS;
		end else begin
			rl_state <= next_rl_state;
		end
	end
	logic lockout_status;
	logic remote_status;
	assign lockout_status = (rl_state == RL_LWLS) || (rl_state == RL_RWLS);
	assign remote_status  = (rl_state == RL_REMS) || (rl_state == RL_RWLS);
	// ************************************************************
	// status flags
	// ************************************************************
	// flags set on the rising edge of their condition, so a level that
	// stays true after a read-clear does not raise the flag again
	logic srq_in_cond;
	logic srq_in_cond_q;
	logic cmd_out_cond;
	logic cmd_out_cond_q;
	logic service_request_input_flag;
	logic command_output_flag;
	logic next_service_request_input_flag;
	logic next_command_output_flag;
	logic next_srq_in_cond_q;
	logic next_cmd_out_cond_q;
	assign srq_in_cond  = in_charge_s && srq_s && !rqsdav_s;
	assign cmd_out_cond = cacs_s && sgns_s;
	always_comb begin
		next_service_request_input_flag = service_request_input_flag;
		next_command_output_flag        = command_output_flag;
		next_srq_in_cond_q              = srq_in_cond_q;
		next_cmd_out_cond_q             = cmd_out_cond_q;
		if (!read_busy) begin
			next_srq_in_cond_q  = srq_in_cond;
			next_cmd_out_cond_q = cmd_out_cond;
			if (rd_status) begin
				next_service_request_input_flag = 1'b0;
			end
			if (srq_in_cond && !srq_in_cond_q) begin
				next_service_request_input_flag = 1'b1;
			end
			if (rd_status || !cacs_s || !sgns_s) begin
				next_command_output_flag = 1'b0;
			end
			if (cmd_out_cond && !cmd_out_cond_q) begin
				next_command_output_flag = 1'b1;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			service_request_input_flag <= 1'b0;
			command_output_flag        <= 1'b0;
			srq_in_cond_q              <= 1'b0;
			cmd_out_cond_q             <= 1'b0;
		end else begin
			service_request_input_flag <= next_service_request_input_flag;
			command_output_flag        <= next_command_output_flag;
			srq_in_cond_q              <= next_srq_in_cond_q;
			cmd_out_cond_q             <= next_cmd_out_cond_q;
		end
	end
	// ************************************************************
	// mask register
	// ************************************************************
	logic [7:0] interrupt_mask_two;
	logic [7:0] next_mask;
	logic       command_output_irq_enable;
	logic       srq_in_irq_enable;
	always_comb begin
		next_mask = interrupt_mask_two;
		if (wr_mask) begin
			next_mask = pwdata[7:0] & 8'h78;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_mask_two <= MASK_RESET;
		end else begin
			interrupt_mask_two <= next_mask;
		end
	end
	// dma is not implemented; the enables are only mirrored out
	assign command_output_irq_enable = interrupt_mask_two[POS_CMD_OUT];
	assign srq_in_irq_enable         = interrupt_mask_two[POS_SRQ_IN];
	// ************************************************************
	// read data, interrupt, outputs
	// ************************************************************
	logic [7:0]  interrupt_status_two;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        next_irq;
	logic        next_dma_out_enable;
	logic        next_dma_in_enable;
	logic        mapped;
	assign interrupt_status_two = {1'b0, service_request_input_flag, lockout_status,
		remote_status, command_output_flag, 3'b000};
	assign mapped = (paddr == ADDR_STATUS_TWO) || (paddr == ADDR_MASK_TWO) ||
		(paddr == ADDR_RL_STATE);
	// lockout excluded on purpose: it is a plain state bit
	// built from next values so irq always agrees with the flags and mask beside it
	assign next_irq = (next_service_request_input_flag && next_mask[POS_SRQ_IN]) ||
		(next_command_output_flag && next_mask[POS_CMD_OUT]);
	always_comb begin
		next_prdata = READ_ZERO;
		if (psel && !penable && !pwrite) begin
			if (paddr == ADDR_STATUS_TWO) begin
				next_prdata = {24'h000000, interrupt_status_two};
			end else if (paddr == ADDR_MASK_TWO) begin
				next_prdata = READ_ZERO;
			end else if (paddr == ADDR_RL_STATE) begin
				next_prdata = {29'h00000000, rl_state};
			end else begin
				next_prdata = READ_ZERO;
			end
		end else if (access) begin
			next_prdata = prdata;
		end
	end
	always_comb begin
		next_pready         = psel && !penable;
		next_pslverr        = psel && !penable && !mapped;
		next_dma_out_enable = next_mask[POS_DMA_OUT];
		next_dma_in_enable  = next_mask[POS_DMA_IN];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata         <= READ_ZERO;
			pready         <= 1'b0;
			pslverr        <= 1'b0;
			irq            <= 1'b0;
			dma_out_enable <= 1'b0;
			dma_in_enable  <= 1'b0;
		end else begin
			prdata         <= next_prdata;
			pready         <= next_pready;
			pslverr        <= next_pslverr;
			irq            <= next_irq;
			dma_out_enable <= next_dma_out_enable;
			dma_in_enable  <= next_dma_in_enable;
		end
	end
	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	srq_in_set_a: assert property (!read_busy && srq_in_cond && !srq_in_cond_q
		|=> service_request_input_flag) else $error("request flag not set");
	srq_in_clr_a: assert property (rd_status && !(srq_in_cond && !srq_in_cond_q)
		|=> !service_request_input_flag) else $error("request flag not cleared");
	lockout_bit_a: assert property (lockout_status == (rl_state inside {RL_LWLS, RL_RWLS}))
		else $error("lockout bit wrong");
	lockout_noirq_a: assert property (!service_request_input_flag && !command_output_flag
		|-> !irq) else $error("irq without source");
	remote_bit_a: assert property (remote_status == (rl_state inside {RL_REMS, RL_RWLS}))
		else $error("remote bit wrong");
	remote_entry_a: assert property ($rose(remote_status)
		|-> $past(ren_s) && $past(ladr_s)) else $error("remote entered illegally");
	cmd_out_set_a: assert property (!read_busy && cmd_out_cond && !cmd_out_cond_q
		|=> command_output_flag) else $error("command flag not set");
	cmd_out_clr_a: assert property (!read_busy && !cmd_out_cond
		|=> !command_output_flag) else $error("command flag not cleared");
	hold_a: assert property (read_busy |=> $stable(service_request_input_flag) &&
		$stable(command_output_flag)) else $error("change during read");
	irq_or_a: assert property (irq == ((service_request_input_flag && srq_in_irq_enable)
		|| (command_output_flag && command_output_irq_enable))) else $error("irq mismatch");
	srq_in_c: cover property (service_request_input_flag && irq);
	cmd_out_c: cover property (command_output_flag ##1 rd_status);
	rwls_c: cover property (rl_state == RL_RWLS);
	cmd_irq_c: cover property (command_output_flag && irq);
endmodule

// ==== verification/gpib_far_side.sv ====
`timescale 1ns/1ps
// ************************************************************
// bus-side model: controller, system controller and other devices
// ************************************************************
module gpib_far_side (
	input  wire logic pclk,
	output logic      controller_in_charge,
	output logic      bus_srq,
	output logic      rqs_dav,
	output logic      cacs,
	output logic      sgns,
	output logic      bus_ren,
	output logic      listen_addressed,
	output logic      go_local,
	output logic      lockout_cmd
);
	initial begin
		{controller_in_charge, bus_srq, rqs_dav, cacs, sgns} = 5'h00;
		{bus_ren, listen_addressed, go_local, lockout_cmd} = 4'h0;
	end
	// order: cic srq rqs_dav cacs sgns ren listen go_local lockout
	task automatic drive(input logic [8:0] v);
		@(posedge pclk);
		{controller_in_charge, bus_srq, rqs_dav, cacs, sgns} <= v[8:4];
		bus_ren          <= v[3];
		listen_addressed <= v[2] & v[3];
		go_local         <= v[1];
		lockout_cmd      <= v[0];
	endtask
endmodule

// ==== verification/tb_gpib_interrupt_status_two_mid.sv ====
`timescale 1ns/1ps
module tb_gpib_interrupt_status_two_mid;
	import gpib_interrupt_status_two_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic        dma_out_enable, dma_in_enable, last_err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        controller_in_charge, bus_srq, rqs_dav, cacs, sgns;
	logic        bus_ren, listen_addressed, go_local, lockout_cmd;
	int          num_errors, num_checks;
	gpib_interrupt_status_two_mid gpib_interrupt_status_two_mid_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.controller_in_charge(controller_in_charge), .bus_srq(bus_srq),
		.rqs_dav(rqs_dav), .cacs(cacs), .sgns(sgns), .bus_ren(bus_ren),
		.listen_addressed(listen_addressed), .go_local(go_local),
		.lockout_cmd(lockout_cmd), .irq(irq), .dma_out_enable(dma_out_enable),
		.dma_in_enable(dma_in_enable));
	gpib_far_side gpib_far_side_i (.pclk(pclk), .controller_in_charge(controller_in_charge),
		.bus_srq(bus_srq), .rqs_dav(rqs_dav), .cacs(cacs), .sgns(sgns), .bus_ren(bus_ren),
		.listen_addressed(listen_addressed), .go_local(go_local), .lockout_cmd(lockout_cmd));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic results;
		if (num_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer; waits on pready, bounded so a dead slave cannot hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) check("pready", {31'h0, pready}, 32'h0000_0001);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb(1'b0, a, 32'h0000_0000, q);
		check(nm, q, exp);
	endtask
	// two sync flops plus the flag register, with margin
	task automatic bus(input logic [8:0] v);
		gpib_far_side_i.drive(v);
		repeat (6) @(posedge pclk);
	endtask
	// one edge first, so a change launched by the last access edge has settled
	task automatic irq_is(input logic e);
		@(posedge pclk);
		check("irq", {31'h0, irq}, {31'h0, e});
	endtask
	initial begin
		#(25 * 4000);
		num_errors++;
		results();
	end
	initial begin
		num_errors = 0; num_checks = 0;
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0000_0000; last_err = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd("status", ADDR_STATUS_TWO, 32'h0000_0000);
		rd("unmapped", 8'h10, 32'h0000_0000);
		check("pslverr", {31'h0, last_err}, 32'h0000_0001);
		bus(9'h030);
		irq_is(1'b0);
		rd("status", ADDR_STATUS_TWO, 32'h0000_0008);
		rd("status", ADDR_STATUS_TWO, 32'h0000_0000);
		bus(9'h000);
		// software keeps both dma enables clear
		wr(ADDR_MASK_TWO, 32'h0000_0048);
		rd("mask", ADDR_MASK_TWO, 32'h0000_0000);
		check("dma", {30'h0, dma_out_enable, dma_in_enable}, 32'h0000_0000);
		bus(9'h1C0);
		rd("status", ADDR_STATUS_TWO, 32'h0000_0000);
		bus(9'h180);
		irq_is(1'b1);
		rd("status", ADDR_STATUS_TWO, 32'h0000_0040);
		rd("status", ADDR_STATUS_TWO, 32'h0000_0000);
		irq_is(1'b0);
		bus(9'h000);
		bus(9'h030);
		irq_is(1'b1);
		bus(9'h020);
		irq_is(1'b0);
		rd("status", ADDR_STATUS_TWO, 32'h0000_0000);
		bus(9'h000);
		wr(ADDR_MASK_TWO, 32'h0000_0040);
		bus(9'h030);
		irq_is(1'b0);
		rd("status", ADDR_STATUS_TWO, 32'h0000_0008);
		bus(9'h000);
		bus(9'h008);
		rd("status", ADDR_STATUS_TWO, 32'h0000_0000);
		bus(9'h00C);
		rd("status", ADDR_STATUS_TWO, 32'h0000_0010);
		rd("rl_state", ADDR_RL_STATE, 32'h0000_0001);
		wr(ADDR_MASK_TWO, 32'h0000_0048);
		bus(9'h00D);
		rd("status", ADDR_STATUS_TWO, 32'h0000_0030);
		rd("rl_state", ADDR_RL_STATE, 32'h0000_0003);
		irq_is(1'b0);
		results();
	end
endmodule
